// >>> rtl/flash_host_pkg.sv
package flash_host_pkg;

    // Bus timing at 25 MHz
    localparam int unsigned CLK_MHZ         = 25;
    localparam int unsigned BUS_CYCLES      = 3;
    localparam int unsigned VERIFY_WAIT_NS  = 400;
    localparam int unsigned VERIFY_WAIT_CYC =
        (VERIFY_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned UNPROT_WAIT_MS  = 15;
    localparam int unsigned UNPROT_WAIT_CYC = UNPROT_WAIT_MS * CLK_MHZ * 1000;
    localparam int unsigned VID_SETTLE_NS   = 1000;
    localparam int unsigned VID_SETTLE_CYC  = VID_SETTLE_NS * CLK_MHZ / 1000;
    localparam int unsigned PULSE_LIMIT     = 1000;

    // Command bytes
    localparam logic [7:0] CMD_UNPROTECT = 8'h60;
    localparam logic [7:0] CMD_VERIFY    = 8'h40;
    localparam logic [7:0] CMD_RESET     = 8'hF0;
    localparam logic [7:0] VERIFY_OK     = 8'h00;

    // Unprotect address pattern: A6 = 1, A1 = 1, A0 = 0
    localparam logic [21:0] UNPROT_MASK = 22'h000043;
    localparam logic [21:0] UNPROT_BITS = 22'h000042;

    // Status bit positions
    localparam int unsigned BIT_POLL   = 7;
    localparam int unsigned BIT_TOGGLE = 6;
    localparam int unsigned BIT_LIMIT  = 5;
    localparam int unsigned BIT_ERASE2 = 2;

    // Host register map
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_DATA   = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ    = 4'h4;
    localparam logic [3:0] REG_MASK   = 4'h5;
    localparam logic [3:0] REG_GROUPS = 4'h6;

    // Control opcodes written to REG_CTRL
    localparam logic [2:0] OP_READ    = 3'h1;
    localparam logic [2:0] OP_WRITE   = 3'h2;
    localparam logic [2:0] OP_POLL    = 3'h3;
    localparam logic [2:0] OP_UNPROT  = 3'h4;

    // Result codes
    localparam logic [2:0] RES_NONE    = 3'h0;
    localparam logic [2:0] RES_DONE    = 3'h1;
    localparam logic [2:0] RES_FAIL    = 3'h2;
    localparam logic [2:0] RES_DEVFAIL = 3'h3;

    // Interrupt event bits
    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_FAIL = 1;
    localparam int unsigned EV_RDY  = 2;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [21:0] addr;
        logic [7:0]  dq_out;
        logic        dq_oe;
        logic        vid_on;
    } flash_pins_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } host_bus_t;

endpackage : flash_host_pkg

// >>> rtl/flash_cycle.sv
`timescale 1ns/1ns
// One asynchronous flash bus cycle, stretched over BUS_CYCLES clocks
module flash_cycle
    import flash_host_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Request
    input  wire logic        start,
    input  wire logic        write,
    input  wire logic [21:0] addr,
    input  wire logic [7:0]  wdata,
    // Flash pins
    input  wire logic [7:0]  dq_in,
    output flash_pins_t      pins,
    // Completion
    output logic             done,
    output logic [7:0]       rdata
);
    logic [1:0]  cnt_q, cnt_d;
    logic        busy_q, busy_d, wr_q, wr_d, done_d;
    flash_pins_t pins_d;
    logic [7:0]  rdata_d;

    always_comb
    begin
        cnt_d   = cnt_q;
        busy_d  = busy_q;
        wr_d    = wr_q;
        pins_d  = pins;
        rdata_d = rdata;
        done_d  = 1'b0;
        // Rest a clock after done: the caller's next state sets the request
        if (!busy_q && !done && start)
        begin
            busy_d        = 1'b1;
            wr_d          = write;
            cnt_d         = 2'(BUS_CYCLES - 1);
            pins_d.addr   = addr;
            pins_d.dq_out = wdata;
            pins_d.ce_n   = 1'b0;
            pins_d.oe_n   = write;
            pins_d.we_n   = !write;
            pins_d.dq_oe  = write;
        end
        else if (busy_q)
        begin
            if (cnt_q != 2'h0)
                cnt_d = cnt_q - 2'h1;
            else
            begin
                // Write data latched on rising strobe; sample before release
                if (!wr_q)
                    rdata_d = dq_in;
                pins_d.ce_n  = 1'b1;
                pins_d.oe_n  = 1'b1;
                pins_d.we_n  = 1'b1;
                pins_d.dq_oe = 1'b0;
                busy_d       = 1'b0;
                done_d       = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q  <= 2'h0;
            busy_q <= 1'b0;
            wr_q   <= 1'b0;
            done   <= 1'b0;
            rdata  <= 8'h00;
            pins   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        addr: 22'h0, dq_out: 8'h00, dq_oe: 1'b0,
                        vid_on: 1'b0};
        end
        else
        begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            wr_q   <= wr_d;
            done   <= done_d;
            rdata  <= rdata_d;
            pins   <= pins_d;
        end
    end
endmodule : flash_cycle

// >>> rtl/flash_host.sv
`timescale 1ns/1ns
// How it works
// - Host combines bits 2 and 6
// - Host reads twice, compares toggle bits
// - Bit 5 high means recheck, else read again
// - Host rereads status after completion
// - High voltage, write 60H, wait 15 ms
// - Write 40h, wait 0.4 us, expect 00h
module flash_host
    import flash_host_pkg::*;
#(
    parameter int unsigned UNPROT_WAIT = UNPROT_WAIT_CYC,
    parameter int unsigned MAX_PULSES  = PULSE_LIMIT
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Register port
    input  host_bus_t        bus,
    output logic [31:0]      rdata,
    output logic             irq,
    // Flash pins
    input  wire logic [7:0]  dq_in,
    input  wire logic        ready_busy_output,
    output flash_pins_t      pins
);
    import flash_host_pkg::*;

    typedef enum {
        ST_IDLE, ST_RD, ST_WR, ST_P1, ST_P2, ST_P3, ST_P4, ST_RST,
        ST_VSET, ST_UPW, ST_UWAIT, ST_VW, ST_VWAIT, ST_VRD, ST_VOFF
    } state_t;

    state_t      st_q, st_d;
    logic [21:0] addr_q, addr_d;
    logic [7:0]  data_q, data_d, first_q, first_d;
    logic [2:0]  res_q, res_d;
    logic [2:0]  ev_q, ev_d, mask_q, mask_d;
    logic [7:0]  groups_q, groups_d, grp_q, grp_d;
    logic [31:0] wait_q, wait_d;
    logic [15:0] pulse_q, pulse_d;
    logic        vid_q, vid_d, irq_d, cyc_go, cyc_wr;
    logic [31:0] rdata_d;
    logic [7:0]  cyc_wdata, cyc_rdata;
    logic [21:0] cyc_addr;
    logic        cyc_done;
    logic [2:0]  ev_set;
    logic        rdy_q;
    flash_pins_t cyc_pins;

    // Toggle seen between two reads on bit 6 or bit 2
    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
        return (a[BIT_TOGGLE] ^ b[BIT_TOGGLE]) | (a[BIT_ERASE2] ^ b[BIT_ERASE2]);
    endfunction : toggled

    function automatic logic [21:0] unprot_addr(input logic [21:0] a);
        return (a & ~UNPROT_MASK) | UNPROT_BITS;
    endfunction : unprot_addr

    flash_cycle u_cycle (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (cyc_go),
        .write   (cyc_wr),
        .addr    (cyc_addr),
        .wdata   (cyc_wdata),
        .dq_in   (dq_in),
        .pins    (cyc_pins),
        .done    (cyc_done),
        .rdata   (cyc_rdata)
    );

    always_comb
    begin
        st_d     = st_q;
        addr_d   = addr_q;
        data_d   = data_q;
        first_d  = first_q;
        res_d    = res_q;
        mask_d   = mask_q;
        groups_d = groups_q;
        grp_d    = grp_q;
        wait_d   = wait_q;
        pulse_d  = pulse_q;
        vid_d    = vid_q;
        ev_set   = 3'h0;
        cyc_go   = 1'b0;
        cyc_wr   = 1'b0;
        cyc_addr = addr_q;
        cyc_wdata = data_q;
        rdata_d  = 32'h0;

        if (bus.rd)
        begin
            case (bus.addr)
                REG_ADDR:   rdata_d = {10'h0, addr_q};
                REG_DATA:   rdata_d = {24'h0, data_q};
                REG_STATUS: rdata_d = {16'h0, pulse_q[7:0], 1'b0, rdy_q,
                                       vid_q, (st_q != ST_IDLE), 1'b0, res_q};
                REG_IRQ:    rdata_d = {29'h0, ev_q};
                REG_MASK:   rdata_d = {29'h0, mask_q};
                REG_GROUPS: rdata_d = {24'h0, groups_q};
                default:    rdata_d = 32'h0;
            endcase
        end
        if (bus.wr)
        begin
            case (bus.addr)
                REG_ADDR:   addr_d   = bus.wdata[21:0];
                REG_DATA:   data_d   = bus.wdata[7:0];
                REG_MASK:   mask_d   = bus.wdata[2:0];
                REG_GROUPS: groups_d = bus.wdata[7:0];
                default:    ;
            endcase
        end

        case (st_q)
            ST_IDLE:
                if (bus.wr && bus.addr == REG_CTRL)
                begin
                    res_d = RES_NONE;
                    case (bus.wdata[2:0])
                        OP_READ:  st_d = ST_RD;
                        OP_WRITE: st_d = ST_WR;
                        OP_POLL:  st_d = ST_P1;
                        OP_UNPROT:
                        begin
                            // Software must have protected every group first
                            grp_d   = 8'h0;
                            pulse_d = 16'h1;
                            vid_d   = 1'b1;
                            wait_d  = VID_SETTLE_CYC;
                            st_d    = ST_VSET;
                        end
                        default:  ;
                    endcase
                end
            ST_RD:
            begin
                cyc_go = 1'b1;
                if (cyc_done)
                begin
                    data_d = cyc_rdata;
                    res_d  = RES_DONE;
                    st_d   = ST_IDLE;
                end
            end
            ST_WR:
            begin
                cyc_go = 1'b1;
                cyc_wr = 1'b1;
                if (cyc_done)
                begin
                    res_d = RES_DONE;
                    st_d  = ST_IDLE;
                end
            end
            // Toggle polling: two reads compared on bits 6 and 2
            ST_P1:
            begin
                cyc_go = 1'b1;
                if (cyc_done)
                begin
                    first_d = cyc_rdata;
                    st_d    = ST_P2;
                end
            end
            ST_P2:
            begin
                cyc_go = 1'b1;
                if (cyc_done)
                begin
                    // Bits 6 and 2 together tell mode and sector
                    if (!toggled(first_q, cyc_rdata))
                        st_d = ST_P4;
                    else if (cyc_rdata[BIT_LIMIT])
                        st_d = ST_P3;
                    else
                        st_d = ST_P1;
                    first_d = cyc_rdata;
                end
            end
            ST_P3:
            begin
                cyc_go = 1'b1;
                if (cyc_done)
                begin
                    // Toggle may stop just as the limit bit rises
                    if (toggled(first_q, cyc_rdata))
                    begin
                        data_d = CMD_RESET;
                        res_d  = RES_FAIL;
                        st_d   = ST_RST;
                    end
                    else
                        st_d = ST_P4;
                end
            end
            ST_P4:
            begin
                cyc_go = 1'b1;
                if (cyc_done)
                begin
                    // Earlier read may have caught bits in transition
                    data_d = cyc_rdata;
                    if (res_q == RES_NONE)
                        res_d = RES_DONE;
                    st_d = ST_IDLE;
                end
            end
            ST_RST:
            begin
                cyc_go    = 1'b1;
                cyc_wr    = 1'b1;
                cyc_wdata = CMD_RESET;
                if (cyc_done)
                    st_d = ST_IDLE;
            end
            ST_VSET:
                if (wait_q <= 32'h1)
                    st_d = ST_UPW;
                else
                    wait_d = wait_q - 32'h1;
            ST_UPW:
            begin
                cyc_go    = 1'b1;
                cyc_wr    = 1'b1;
                cyc_addr  = unprot_addr({grp_q, 14'h0});
                cyc_wdata = CMD_UNPROTECT;
                if (cyc_done)
                begin
                    wait_d = UNPROT_WAIT;
                    st_d   = ST_UWAIT;
                end
            end
            ST_UWAIT:
                if (wait_q <= 32'h1)
                    st_d = ST_VW;
                else
                    wait_d = wait_q - 32'h1;
            ST_VW:
            begin
                cyc_go    = 1'b1;
                cyc_wr    = 1'b1;
                cyc_addr  = unprot_addr({grp_q, 14'h0});
                cyc_wdata = CMD_VERIFY;
                if (cyc_done)
                begin
                    wait_d = VERIFY_WAIT_CYC;
                    st_d   = ST_VWAIT;
                end
            end
            ST_VWAIT:
                if (wait_q <= 32'h1)
                    st_d = ST_VRD;
                else
                    wait_d = wait_q - 32'h1;
            ST_VRD:
            begin
                cyc_go   = 1'b1;
                cyc_addr = unprot_addr({grp_q, 14'h0});
                if (cyc_done)
                begin
                    data_d = cyc_rdata;
                    if (cyc_rdata == VERIFY_OK)
                    begin
                        if (grp_q == groups_q)
                        begin
                            res_d = RES_DONE;
                            st_d  = ST_VOFF;
                        end
                        else
                        begin
                            grp_d = grp_q + 8'h1;
                            st_d  = ST_VW;
                        end
                    end
                    else if (pulse_q >= 16'(MAX_PULSES))
                    begin
                        res_d = RES_DEVFAIL;
                        st_d  = ST_VOFF;
                    end
                    else
                    begin
                        pulse_d = pulse_q + 16'h1;
                        st_d    = ST_UPW;
                    end
                end
            end
            ST_VOFF:
            begin
                vid_d  = 1'b0;
                data_d = CMD_RESET;
                st_d   = ST_RST;
            end
            default:
                st_d = ST_IDLE;
        endcase

        if (res_d != res_q && res_d == RES_DONE)
            ev_set[EV_DONE] = 1'b1;
        if (res_d != res_q && res_d >= RES_FAIL)
            ev_set[EV_FAIL] = 1'b1;
        // Ready edge on the device's open-drain line
        if (ready_busy_output && !rdy_q)
            ev_set[EV_RDY] = 1'b1;
        ev_d = ev_q;
        if (bus.wr && bus.addr == REG_IRQ)
            ev_d = ev_q & ~bus.wdata[2:0];
        ev_d  = ev_d | ev_set;
        irq_d = |(ev_d & mask_d);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q     <= ST_IDLE;
            addr_q   <= 22'h0;
            data_q   <= 8'h00;
            first_q  <= 8'h00;
            res_q    <= RES_NONE;
            ev_q     <= 3'h0;
            mask_q   <= 3'h0;
            groups_q <= 8'h00;
            grp_q    <= 8'h00;
            wait_q   <= 32'h0;
            pulse_q  <= 16'h0;
            vid_q    <= 1'b0;
            rdy_q    <= 1'b1;
            irq      <= 1'b0;
            rdata    <= 32'h0;
        end
        else
        begin
            st_q     <= st_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            first_q  <= first_d;
            res_q    <= res_d;
            ev_q     <= ev_d;
            mask_q   <= mask_d;
            groups_q <= groups_d;
            grp_q    <= grp_d;
            wait_q   <= wait_d;
            pulse_q  <= pulse_d;
            vid_q    <= vid_d;
            rdy_q    <= ready_busy_output;
            irq      <= irq_d;
            rdata    <= rdata_d;
        end
    end

    // Pin fields come from cycle flops; high voltage from vid_q
    always_comb
    begin
        pins        = cyc_pins;
        pins.vid_on = vid_q;
    end
endmodule : flash_host

// >>> tb/flash_host_props.sv
`timescale 1ns/1ns
module flash_host_props
    import flash_host_pkg::*;
#(
    parameter int unsigned UNPROT_WAIT = 20
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // Register port
    input host_bus_t        bus,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    // Flash pins
    input wire logic [7:0]  dq_in,
    input wire logic        ready_busy_output,
    input flash_pins_t      pins
);
    logic [15:0] gap_q, gap_d, vid_q, vid_d;
    logic [7:0]  cmd_q, cmd_d;

    always_comb
    begin
        gap_d = (!pins.we_n) ? 16'h0000 : gap_q + 16'h0001;
        vid_d = (!pins.vid_on) ? 16'h0000 : vid_q + 16'h0001;
        cmd_d = (!pins.we_n) ? pins.dq_out : cmd_q;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap_q <= 16'h0000;
            vid_q <= 16'h0000;
            cmd_q <= 8'h00;
        end
        else
        begin
            gap_q <= gap_d;
            vid_q <= vid_d;
            cmd_q <= cmd_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_rd_low;
        (!pins.oe_n && !pins.ce_n)[*3];
    endsequence
    sequence s_wr_low;
        (!pins.we_n && pins.dq_oe)[*3];
    endsequence

    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read slot");
    a_read_len: assert property ($fell(pins.oe_n) |-> s_rd_low ##1 pins.oe_n)
        else $error("read strobe not three clocks");
    a_write_len: assert property ($fell(pins.we_n) |-> s_wr_low ##1 pins.we_n)
        else $error("write strobe not three clocks");
    a_no_fight: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
        else $error("host drives data during read");
    a_addr_hold: assert property (!pins.ce_n && $past(!pins.ce_n) |-> $stable(pins.addr))
        else $error("address moved inside a cycle");
    a_vid_addr: assert property (pins.vid_on && !pins.ce_n |->
        (pins.addr & UNPROT_MASK) == UNPROT_BITS)
        else $error("unprotect address pattern wrong");
    a_vid_cmds: assert property (pins.vid_on && !pins.we_n |->
        pins.dq_out == CMD_UNPROTECT || pins.dq_out == CMD_VERIFY)
        else $error("bad command under high voltage");
    a_vid_settle: assert property (pins.vid_on && $fell(pins.we_n) |->
        vid_q >= VID_SETTLE_CYC)
        else $error("write before high voltage settled");
    a_unprot_wait: assert property (pins.vid_on && $fell(pins.we_n) &&
        pins.dq_out == CMD_VERIFY && cmd_q == CMD_UNPROTECT |->
        gap_q >= UNPROT_WAIT)
        else $error("verify written too soon");
    a_verify_wait: assert property (pins.vid_on && $fell(pins.oe_n) |->
        cmd_q == CMD_VERIFY && gap_q >= VERIFY_WAIT_CYC)
        else $error("verify read too soon");
    a_exit_reset: assert property ($fell(pins.vid_on) |->
        ##[1:40] ($fell(pins.we_n) && pins.dq_out == CMD_RESET))
        else $error("no reset command after unprotect");
endmodule : flash_host_props

// >>> tb/flash_dev_model.sv
`timescale 1ns/1ns
module flash_dev_model
    import flash_host_pkg::*;
(
    // Bench control
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic [2:0] mode,
    input  wire logic [7:0] arr_data,
    input  wire logic [3:0] busy_reads,
    input  wire logic [3:0] need_pulses,
    // Device pins
    input  flash_pins_t     pins,
    output logic [7:0]      dq_in,
    output logic            ready_busy_output
);
    logic [7:0] stat, last, cmd;
    logic       tog, halted, ver, rd_q, wr_q, busy;
    int         left, pulses;

    initial
    begin
        {tog, halted, ver, rd_q, wr_q} = 5'h00;
        {last, cmd} = 16'h0000;
        left = 0;
        pulses = 0;
    end

    // Mode 2 is an erase that runs into its limit and never ends by itself;
    // mode 4 reads inside an erase-suspended sector
    assign busy = !halted && (mode == 3'h2 || (mode != 3'h0 && left != 0));
    assign ready_busy_output = !busy;

    always_comb
    begin
        if (ver)
            stat = (pulses >= int'(need_pulses)) ? VERIFY_OK : 8'h01;
        else if (mode == 3'h4)
            stat = {1'b1, arr_data[6], 1'b0, arr_data[4:3], tog,
                    arr_data[1:0]};
        else if (!busy)
            stat = arr_data;
        else if (mode == 3'h1)
            stat = {~arr_data[7], tog, 1'b0, arr_data[4:0]};
        else
            stat = {1'b0, tog, mode == 3'h2, 2'b01, tog, 2'b00};
    end

    // Released bus shows the inverse of the last value driven
    assign dq_in = (!pins.ce_n && !pins.oe_n) ? stat : ~last;

    always @(posedge ref_clk)
    begin
        // Non-blocking so the host never samples a half-updated status
        if (rd_q && pins.oe_n)
        begin
            last <= stat;
            tog  <= ~tog;
            if (left > 0)
                left <= left - 1;
        end
        rd_q <= !pins.ce_n && !pins.oe_n;
        if (wr_q && pins.we_n)
        begin
            if (pins.vid_on && cmd == CMD_UNPROTECT)
            begin
                pulses <= pulses + 1;
                ver    <= 1'b0;
            end
            else if (pins.vid_on && cmd == CMD_VERIFY)
                ver <= 1'b1;
            else if (cmd == CMD_RESET)
            begin
                halted <= 1'b1;
                ver    <= 1'b0;
            end
        end
        if (!pins.we_n)
            cmd <= pins.dq_out;
        wr_q <= !pins.we_n;
        if (go)
        begin
            left <= int'(busy_reads);
            {halted, ver} <= 2'b00;
            pulses <= 0;
        end
    end
endmodule : flash_dev_model

// >>> tb/test_flash_host.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module test_flash_host;
    import flash_host_pkg::*;
    logic        ref_clk, sys_rst, irq, rb, go;
    host_bus_t   hb;
    logic [31:0] rdata, v;
    logic [7:0]  dq_in, arr, sus;
    flash_pins_t pins;
    logic [2:0]  mode;
    logic [3:0]  nbusy, npulse;
    int          failures, checks_done, seed;

    flash_host #(.UNPROT_WAIT(20), .MAX_PULSES(3)) i_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .bus(hb), .rdata(rdata), .irq(irq),
        .dq_in(dq_in), .ready_busy_output(rb), .pins(pins));
    flash_dev_model i_dev (.ref_clk(ref_clk), .go(go), .mode(mode),
        .arr_data(arr), .busy_reads(nbusy), .need_pulses(npulse),
        .pins(pins), .dq_in(dq_in), .ready_busy_output(rb));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        #(40 * 60000);
        failures++;
        end_of_test();
    end

    task end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hb.addr <= a;
        hb.wdata <= d;
        hb.wr <= 1'b1;
        @(posedge ref_clk);
        hb.wr <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        hb.addr <= a;
        hb.rd <= 1'b1;
        @(posedge ref_clk);
        hb.rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task run(input logic [2:0] op, input logic [2:0] res);
        int n;
        reg_wr(REG_CTRL, {29'h0, op});
        n = 0;
        do
        begin
            reg_rd(REG_STATUS, v);
            n++;
        end
        while (v[4] !== 1'b0 && n < 3000);
        `CHK("busy", 1'b0, v[4])
        `CHK("result", res, v[2:0])
    endtask : run

    task kick(input logic [2:0] m, input logic [3:0] b);
        mode <= m;
        nbusy <= b;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask : kick

    initial
    begin
        seed = 75849;
        hb = '0;
        {mode, arr, nbusy, npulse, go} = '0;
        failures = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        reg_rd(REG_STATUS, v);
        `CHK("status reset", 32'h0000_0040, v)
        reg_rd(4'hF, v);
        `CHK("unmapped", 32'h0, v)
        reg_wr(REG_MASK, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            arr <= 8'($random(seed));
            reg_wr(REG_ADDR, {10'h0, 22'($random(seed))});
            run(OP_READ, RES_DONE);
            reg_rd(REG_DATA, v);
            `CHK("array", arr, v[7:0])
        end
        for (int i = 0; i < 6; i++)
        begin
            arr <= (i % 2 == 1) ? 8'hFF : 8'($random(seed));
            kick((i % 2 == 1) ? 3'h3 : 3'h1, 4'(($random(seed) & 3) + 2));
            run(OP_POLL, RES_DONE);
            reg_rd(REG_DATA, v);
            `CHK("poll data", arr, v[7:0])
            `CHK("irq done", 1'b1, irq)
            reg_wr(REG_IRQ, 32'h7);
            reg_rd(REG_IRQ, v);
            `CHK("irq clear", 1'b0, irq)
        end
        kick(3'h2, 4'h0);
        run(OP_POLL, RES_FAIL);
        `CHK("ready after reset", 1'b1, rb)
        reg_rd(REG_IRQ, v);
        `CHK("fail event", 1'b1, v[EV_FAIL])
        `CHK("masked irq", 1'b0, irq)
        kick(3'h2, 4'h0);
        reg_wr(REG_DATA, {24'h0, CMD_RESET});
        `CHK("stuck busy", 1'b0, rb)
        run(OP_WRITE, RES_DONE);
        `CHK("write reset", 1'b1, rb)
        kick(3'h4, 4'h0);
        run(OP_READ, RES_DONE);
        reg_rd(REG_DATA, v);
        sus = v[7:0];
        run(OP_READ, RES_DONE);
        reg_rd(REG_DATA, v);
        `CHK("suspend status", {1'b1, sus[6], 1'b0}, v[7:5])
        `CHK("suspend toggle", ~sus[2], v[2])
        `CHK("suspend ready", 1'b1, rb)
        reg_wr(REG_GROUPS, 32'h1);
        npulse <= 4'h2;
        kick(3'h0, 4'h0);
        run(OP_UNPROT, RES_DONE);
        `CHK("vid off", 1'b0, pins.vid_on)
        npulse <= 4'hF;
        kick(3'h0, 4'h0);
        run(OP_UNPROT, RES_DEVFAIL);
        `CHK("vid off fail", 1'b0, pins.vid_on)
        end_of_test();
    end
endmodule : test_flash_host

bind flash_host flash_host_props #(.UNPROT_WAIT(UNPROT_WAIT)) i_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .irq(irq), .dq_in(dq_in), .ready_busy_output(ready_busy_output),
    .pins(pins));
